// *** logic/bridge_leg_chopper.sv ***
`timescale 1ns/1ps
module bridge_leg_chopper #(
    parameter int DEAD_COUNT = microstep_pkg::DEAD_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic drive_on,
    input  wire logic reverse,
    input  wire logic level_zero,
    input  wire logic period_start,
    input  wire logic decay_start,
    input  wire logic sense_trip,
    output logic      first_high,
    output logic      first_low,
    output logic      second_high,
    output logic      second_low
);
    import microstep_pkg::*;

    localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_COUNT - 1);

    if (DEAD_COUNT < 1 || DEAD_COUNT > (1 << DEAD_W))
        $error("DEAD_COUNT out of range");

    bridge_type        goal;
    leg_state_type     state;
    logic [DEAD_W-1:0] dead_cnt;
    logic              applied_rev;

    function automatic leg_state_type leg_of(input bridge_type g);
        unique case (g)
            bridge_charge: leg_of = leg_charge;
            bridge_fast:   leg_of = leg_fast;
            default:       leg_of = leg_slow;
        endcase
    endfunction

    function automatic logic [3:0] gates_of(input leg_state_type s, input logic rev);
        unique case (s)
            leg_charge: gates_of = rev ? GATES_FAST : GATES_CHARGE;
            leg_slow:   gates_of = GATES_SLOW;
            leg_fast:   gates_of = rev ? GATES_CHARGE : GATES_FAST;
            leg_dead:   gates_of = GATES_OFF;
        endcase
    endfunction

    // Wanted bridge phase within the chopping period
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            goal <= bridge_slow;
        end else if (period_start) begin
            goal <= level_zero ? bridge_slow : bridge_charge;
        end else if (decay_start) begin
            goal <= bridge_fast;
        end else if (sense_trip && goal == bridge_charge) begin
            goal <= bridge_slow;
        end
    end

    // Every change passes through the all-off state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state       <= leg_dead;
            dead_cnt    <= DEAD_LOAD;
            applied_rev <= 1'b0;
        end else if (!drive_on) begin
            state    <= leg_dead;
            dead_cnt <= DEAD_LOAD;
        end else if (state == leg_dead) begin
            if (dead_cnt != '0) begin
                dead_cnt <= dead_cnt - 1'b1;
            end else begin
                state       <= leg_of(goal);
                applied_rev <= reverse;
            end
        end else if (state != leg_of(goal) || applied_rev != reverse) begin
            state    <= leg_dead;
            dead_cnt <= DEAD_LOAD;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {first_high, first_low, second_high, second_low} <= GATES_OFF;
        end else begin
            {first_high, first_low, second_high, second_low} <=
                drive_on ? gates_of(state, applied_rev) : GATES_OFF;
        end
    end

endmodule

// *** logic/microstep_phase_sequencer.sv ***
`timescale 1ns/1ps
module microstep_phase_sequencer #(
    parameter int DEAD_COUNT = microstep_pkg::DEAD_CYCLES
) (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         step_clock,
    input  wire logic                         rotation_direction,
    input  wire logic                         motion_reset_n,
    input  wire logic                         drive_enable,
    input  wire logic                         sleep_input_n,
    input  wire logic                         resolution_select_a,
    input  wire logic                         resolution_select_b,
    input  wire logic                         torque_select,
    input  wire logic                         sense_phase_a,
    input  wire logic                         sense_phase_b,
    input  wire logic                         chop_oscillator,
    input  wire logic                         home_flag_out_i,
    output logic                              home_flag_out_o,
    output logic                              home_flag_out_oe_n,
    output logic [microstep_pkg::LEVEL_W-1:0] phase_a_level,
    output logic                              phase_a_reverse,
    output logic [microstep_pkg::LEVEL_W-1:0] phase_b_level,
    output logic                              phase_b_reverse,
    output logic                              phase_a_out_first_high,
    output logic                              phase_a_out_first_low,
    output logic                              phase_a_out_second_high,
    output logic                              phase_a_out_second_low,
    output logic                              phase_b_out_first_high,
    output logic                              phase_b_out_first_low,
    output logic                              phase_b_out_second_high,
    output logic                              phase_b_out_second_low,
    output logic                              drive_active
);
    import microstep_pkg::*;

    if (DEAD_COUNT < 1 || DEAD_COUNT > (1 << DEAD_W))
        $error("DEAD_COUNT does not fit the dead-time counter");
    if (INDEX_W != $bits(HOME_INDEX) || QUARTER_STEPS != (1 << (INDEX_W - 2)))
        $error("Step index must span four table quadrants");
    if (CHOP_CYCLES != (1 << $bits(CHOP_LAST)))
        $error("Chop slot counter must wrap after one period");

    logic [SYNC_W-1:0]  sync_first;
    logic [SYNC_W-1:0]  sync_second;

    logic               step_s;
    logic               dir_s;
    logic               rst_n_s;
    logic               enable_s;
    logic               awake_s;
    logic [1:0]         mode_s;
    logic               torque_s;
    logic               sense_a_s;
    logic               sense_b_s;
    logic               osc_s;

    logic               step_prev;
    logic               rst_n_prev;
    logic [1:0]         mode_prev;
    logic               step_event;
    logic [INDEX_W-1:0] step_index;
    logic [INDEX_W-1:0] next_step_index;

    logic               osc_prev;
    logic               osc_rise;
    logic [2:0]         chop_slot;
    logic               period_start;
    logic               decay_start;
    logic               drive_on;

    logic [LEVEL_W:0]   target_a;
    logic [LEVEL_W:0]   target_b;

    // The eleven control and sense pins in sync_first pass two flip-flops before use
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_first  <= '0;
            sync_second <= '0;
        end else begin
            sync_first  <= {step_clock,
                            rotation_direction,
                            motion_reset_n,
                            drive_enable,
                            sleep_input_n,
                            resolution_select_b,
                            resolution_select_a,
                            torque_select,
                            sense_phase_a,
                            sense_phase_b,
                            chop_oscillator};
            sync_second <= sync_first;
        end
    end

    assign step_s    = sync_second[10];
    assign dir_s     = sync_second[9];
    assign rst_n_s   = sync_second[8];
    assign enable_s  = sync_second[7];
    assign awake_s   = sync_second[6];
    assign mode_s    = sync_second[5:4];
    assign torque_s  = sync_second[3];
    assign sense_a_s = sync_second[2];
    assign sense_b_s = sync_second[1];
    assign osc_s     = sync_second[0];

    // Index increment per step for each resolution
    function automatic logic [INDEX_W-1:0] step_increment(input logic [1:0] mode);
        unique case (mode)
            MODE_SIXTEENTH: step_increment = INC_SIXTEENTH;
            MODE_HALF:      step_increment = INC_HALF;
            MODE_QUARTER:   step_increment = INC_QUARTER;
            MODE_EIGHTH:    step_increment = INC_EIGHTH;
        endcase
    endfunction

    // Signed target {reverse, magnitude}; cosine for A, sine for B
    // Table holds one cosine quadrant; odd quadrants of A and even quadrants of B read it backwards
    function automatic logic [LEVEL_W:0] phase_target(input logic [INDEX_W-1:0] idx,
                                                      input logic               sine);
        logic [4:0] near_at;
        logic [4:0] far_at;
        logic [4:0] at;
        logic       neg;
        near_at = {1'b0, idx[3:0]};
        far_at  = QUARTER_STEPS - near_at;
        at      = near_at;
        neg     = 1'b0;
        unique case ({sine, idx[5:4]})
            3'h0: begin
                at  = near_at;
                neg = 1'b0;
            end
            3'h1: begin
                at  = far_at;
                neg = 1'b1;
            end
            3'h2: begin
                at  = near_at;
                neg = 1'b1;
            end
            3'h3: begin
                at  = far_at;
                neg = 1'b0;
            end
            3'h4: begin
                at  = far_at;
                neg = 1'b0;
            end
            3'h5: begin
                at  = near_at;
                neg = 1'b0;
            end
            3'h6: begin
                at  = far_at;
                neg = 1'b1;
            end
            3'h7: begin
                at  = near_at;
                neg = 1'b1;
            end
        endcase
        phase_target = {neg, SINE_QUARTER[at]};
    endfunction

    function automatic logic [LEVEL_W-1:0] torque_scale(input logic [LEVEL_W-1:0] mag,
                                                        input logic               full);
        torque_scale = full ? mag : (mag >> TORQUE_SHIFT);
    endfunction

    // Rising step edge, or step already high as reset lifts
    assign step_event = step_s && (!step_prev || !rst_n_prev);

    // Previous synced values for edge and change detection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_prev  <= 1'b0;
            rst_n_prev <= 1'b0;
            mode_prev  <= MODE_SIXTEENTH;
        end else begin
            step_prev  <= step_s;
            rst_n_prev <= rst_n_s;
            mode_prev  <= mode_s;
        end
    end

    // Sleep freezes the index; motion reset or a mode change sends it home
    always_comb begin
        next_step_index = step_index;
        if (!awake_s) begin
            next_step_index = step_index;
        end else if (!rst_n_s) begin
            next_step_index = HOME_INDEX;
        end else if (mode_s != mode_prev) begin
            next_step_index = HOME_INDEX;
        end else if (step_event) begin
            if (dir_s) begin
                next_step_index = step_index - step_increment(mode_s);
            end else begin
                next_step_index = step_index + step_increment(mode_s);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_index <= HOME_INDEX;
        end else begin
            step_index <= next_step_index;
        end
    end

    assign target_a = phase_target(step_index, 1'b0);
    assign target_b = phase_target(step_index, 1'b1);

    // Current targets for the reference converters
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_a_level   <= '0;
            phase_a_reverse <= 1'b0;
            phase_b_level   <= '0;
            phase_b_reverse <= 1'b0;
        end else begin
            phase_a_level   <= torque_scale(target_a[LEVEL_W-1:0], torque_s);
            phase_a_reverse <= target_a[LEVEL_W];
            phase_b_level   <= torque_scale(target_b[LEVEL_W-1:0], torque_s);
            phase_b_reverse <= target_b[LEVEL_W];
        end
    end

    // Home flag: open drain, enable low while pulling down
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            home_flag_out_o    <= 1'b0;
            home_flag_out_oe_n <= 1'b1;
        end else begin
            home_flag_out_o    <= 1'b0;
            home_flag_out_oe_n <= (step_index != HOME_INDEX);
        end
    end

    // Oscillator cycle count within the chopping period
    assign osc_rise     = osc_s && !osc_prev;
    assign period_start = osc_rise && (chop_slot == CHOP_LAST);
    assign decay_start  = osc_rise && (chop_slot == CHOP_FAST_SLOT);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_prev  <= 1'b0;
            chop_slot <= CHOP_LAST;
        end else begin
            osc_prev <= osc_s;
            if (osc_rise) begin
                chop_slot <= chop_slot + 1'b1;
            end
        end
    end

    assign drive_on = awake_s && enable_s;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_active <= 1'b0;
        end else begin
            drive_active <= drive_on;
        end
    end

    // One chopper per phase, sharing the slot timing
    bridge_leg_chopper #(
        .DEAD_COUNT (DEAD_COUNT)
    ) leg_a (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .drive_on     (drive_on),
        .reverse      (phase_a_reverse),
        .level_zero   (phase_a_level == '0),
        .period_start (period_start),
        .decay_start  (decay_start),
        .sense_trip   (sense_a_s),
        .first_high   (phase_a_out_first_high),
        .first_low    (phase_a_out_first_low),
        .second_high  (phase_a_out_second_high),
        .second_low   (phase_a_out_second_low)
    );

    bridge_leg_chopper #(
        .DEAD_COUNT (DEAD_COUNT)
    ) leg_b (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .drive_on     (drive_on),
        .reverse      (phase_b_reverse),
        .level_zero   (phase_b_level == '0),
        .period_start (period_start),
        .decay_start  (decay_start),
        .sense_trip   (sense_b_s),
        .first_high   (phase_b_out_first_high),
        .first_low    (phase_b_out_first_low),
        .second_high  (phase_b_out_second_high),
        .second_low   (phase_b_out_second_low)
    );

endmodule

// *** logic/microstep_pkg.sv ***
package microstep_pkg;

    localparam int          INDEX_W        = 6;
    localparam int          LEVEL_W        = 7;
    localparam int          SYNC_W         = 11;

    localparam logic [5:0]  HOME_INDEX     = 6'h00;
    localparam logic [5:0]  INC_SIXTEENTH  = 6'h01;
    localparam logic [5:0]  INC_EIGHTH     = 6'h02;
    localparam logic [5:0]  INC_QUARTER    = 6'h04;
    localparam logic [5:0]  INC_HALF       = 6'h08;

    // Resolution code is {select_b, select_a}
    localparam logic [1:0]  MODE_SIXTEENTH = 2'h0;
    localparam logic [1:0]  MODE_HALF      = 2'h1;
    localparam logic [1:0]  MODE_QUARTER   = 2'h2;
    localparam logic [1:0]  MODE_EIGHTH    = 2'h3;

    localparam logic [4:0]  QUARTER_STEPS  = 5'h10;
    localparam logic [6:0]  SINE_QUARTER [0:16] = '{
        7'h64, 7'h64, 7'h62, 7'h60, 7'h5C, 7'h58, 7'h53, 7'h4D, 7'h47,
        7'h3F, 7'h38, 7'h2F, 7'h26, 7'h1D, 7'h14, 7'h0A, 7'h00};
    localparam int          TORQUE_SHIFT   = 2;

    localparam int          CHOP_CYCLES    = 8;
    localparam logic [2:0]  CHOP_LAST      = 3'(CHOP_CYCLES - 1);
    localparam logic [2:0]  CHOP_FAST_SLOT = 3'(CHOP_CYCLES - 2);

    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          DEAD_TIME_NS   = 300;
    localparam int          DEAD_CYCLES    = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DEAD_W         = 4;

    // Gate word {first_high, first_low, second_high, second_low}
    localparam logic [3:0]  GATES_OFF      = 4'h0;
    localparam logic [3:0]  GATES_CHARGE   = 4'h9;
    localparam logic [3:0]  GATES_SLOW     = 4'h5;
    localparam logic [3:0]  GATES_FAST     = 4'h6;

    typedef enum logic [1:0] {bridge_charge, bridge_slow, bridge_fast} bridge_type;
    typedef enum logic [1:0] {leg_dead, leg_charge, leg_slow, leg_fast} leg_state_type;

endpackage

// *** verification/microstep_phase_sequencer_checker.sv ***
`timescale 1ns/1ps
module microstep_phase_sequencer_checker #(
    parameter int DEAD_COUNT = 2
) (
    input wire logic                              ref_clk,
    input wire logic                              sys_rst,
    input wire logic                              step_clock,
    input wire logic                              motion_reset_n,
    input wire logic                              drive_enable,
    input wire logic                              sleep_input_n,
    input wire logic                              resolution_select_a,
    input wire logic                              resolution_select_b,
    input wire logic                              torque_select,
    input wire logic                              home_flag_out_oe_n,
    input wire logic [microstep_pkg::LEVEL_W-1:0] phase_a_level,
    input wire logic                              phase_a_reverse,
    input wire logic [microstep_pkg::LEVEL_W-1:0] phase_b_level,
    input wire logic                              phase_a_out_first_high,
    input wire logic                              phase_a_out_first_low,
    input wire logic                              phase_a_out_second_high,
    input wire logic                              phase_a_out_second_low,
    input wire logic                              phase_b_out_first_high,
    input wire logic                              phase_b_out_first_low,
    input wire logic                              phase_b_out_second_high,
    input wire logic                              phase_b_out_second_low,
    input wire logic                              drive_active
);
    import microstep_pkg::*;

    logic [3:0] ga;
    logic [3:0] gb;
    logic [3:0] zero_run;

    assign ga = {phase_a_out_first_high, phase_a_out_first_low,
                 phase_a_out_second_high, phase_a_out_second_low};
    assign gb = {phase_b_out_first_high, phase_b_out_first_low,
                 phase_b_out_second_high, phase_b_out_second_low};

    // Length of the current all-off run of leg A
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_run <= 4'h0;
        end else if (ga != 4'h0) begin
            zero_run <= 4'h0;
        end else if (zero_run != 4'hF) begin
            zero_run <= zero_run + 4'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_sleep_off: assert property (
        (!sleep_input_n)[*5] |-> {ga, gb} == 8'h00) else $error("Gates on in sleep");
    a_enable_off: assert property (
        (!drive_enable)[*5] |-> {ga, gb} == 8'h00) else $error("Gates on while disabled");
    a_active_follows: assert property (
        (drive_enable && sleep_input_n)[*4] |-> drive_active) else $error("Drive not active");
    a_home_levels: assert property (
        !home_flag_out_oe_n |-> phase_b_level == 7'h00 && !phase_a_reverse
        && (phase_a_level == 7'h64 || phase_a_level == 7'h19)) else $error("Bad home levels");
    a_reset_homes: assert property (
        (!motion_reset_n && sleep_input_n)[*5] |-> !home_flag_out_oe_n)
        else $error("Reset did not home");
    a_leg_no_short: assert property (
        !(ga[3] && ga[2]) && !(ga[1] && ga[0]) && !(gb[3] && gb[2]) && !(gb[1] && gb[0]))
        else $error("Leg shorted");
    a_dead_time: assert property (
        $rose(|ga) |-> zero_run >= DEAD_COUNT) else $error("Dead time too short");
    a_no_direct_switch: assert property (
        (ga != 4'h0 && $past(ga) != 4'h0) |-> ga == $past(ga)) else $error("No dead time");
    a_level_steady: assert property (
        (!step_clock && motion_reset_n
         && $stable({torque_select, resolution_select_a, resolution_select_b}))[*8]
        |-> $stable(phase_a_level) && $stable(phase_b_level)) else $error("Level moved");

    cover property (!home_flag_out_oe_n ##1 home_flag_out_oe_n);
    cover property ($rose(phase_a_reverse));
    cover property (ga == GATES_SLOW);
    cover property (ga == GATES_FAST);
endmodule

bind microstep_phase_sequencer microstep_phase_sequencer_checker #(
    .DEAD_COUNT(DEAD_COUNT)
) checker_inst (
    .ref_clk, .sys_rst, .step_clock, .motion_reset_n, .drive_enable, .sleep_input_n,
    .resolution_select_a, .resolution_select_b, .torque_select, .home_flag_out_oe_n,
    .phase_a_level, .phase_a_reverse, .phase_b_level, .phase_a_out_first_high,
    .phase_a_out_first_low, .phase_a_out_second_high, .phase_a_out_second_low,
    .phase_b_out_first_high, .phase_b_out_first_low, .phase_b_out_second_high,
    .phase_b_out_second_low, .drive_active
);

// *** verification/microstep_phase_sequencer_test.sv ***
`timescale 1ns/1ps
module microstep_phase_sequencer_test;
    import microstep_pkg::*;

    logic       ref_clk, sys_rst, motion_reset_n, drive_enable, sleep_input_n;
    logic       resolution_select_a, resolution_select_b, torque_select;
    logic       step_clock, rotation_direction, chop_oscillator;
    logic       sense_phase_a, sense_phase_b, home_flag_out_i, home_flag_out_o;
    logic       home_flag_out_oe_n, phase_a_reverse, phase_b_reverse, drive_active;
    logic [6:0] phase_a_level, phase_b_level;
    logic       phase_a_out_first_high, phase_a_out_first_low;
    logic       phase_a_out_second_high, phase_a_out_second_low;
    logic       phase_b_out_first_high, phase_b_out_first_low;
    logic       phase_b_out_second_high, phase_b_out_second_low;
    logic [7:0] gates;
    int         error_cnt = 0;
    int         cmp_count = 0;
    localparam logic [5:0] INCS [4] = '{INC_SIXTEENTH, INC_HALF, INC_QUARTER, INC_EIGHTH};

    // Pull-up on the open-drain home flag
    assign home_flag_out_i = home_flag_out_oe_n ? 1'b1 : home_flag_out_o;
    assign gates = {phase_a_out_first_high, phase_a_out_first_low, phase_a_out_second_high,
                    phase_a_out_second_low, phase_b_out_first_high, phase_b_out_first_low,
                    phase_b_out_second_high, phase_b_out_second_low};

    step_host_model host (.ref_clk, .step_clock, .rotation_direction, .chop_oscillator,
                          .sense_phase_a, .sense_phase_b);

    microstep_phase_sequencer #(.DEAD_COUNT(2)) DUT (
        .ref_clk, .sys_rst, .step_clock, .rotation_direction, .motion_reset_n,
        .drive_enable, .sleep_input_n, .resolution_select_a, .resolution_select_b,
        .torque_select, .sense_phase_a, .sense_phase_b, .chop_oscillator,
        .home_flag_out_i, .home_flag_out_o, .home_flag_out_oe_n, .phase_a_level,
        .phase_a_reverse, .phase_b_level, .phase_b_reverse, .phase_a_out_first_high,
        .phase_a_out_first_low, .phase_a_out_second_high, .phase_a_out_second_low,
        .phase_b_out_first_high, .phase_b_out_first_low, .phase_b_out_second_high,
        .phase_b_out_second_low, .drive_active);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a gate word on leg A
    task automatic seek_gates(input logic [3:0] word);
        int n;
        n = 0;
        while (gates[7:4] != word && n < 600) begin
            cyc(1);
            n++;
        end
        chk({3'h0, gates[7:4]}, {3'h0, word});
    endtask

    // Magnitude of the cosine (A) or sine (B) target for an index
    function automatic logic [6:0] mag(input logic [5:0] i, input logic sine);
        logic [4:0] r;
        r = {1'b0, i[3:0]};
        if (i[4] ^ sine) r = QUARTER_STEPS - r;
        return SINE_QUARTER[r];
    endfunction

    task automatic check_pos(input logic [5:0] i);
        logic [6:0] ea;
        logic [6:0] eb;
        ea = mag(i, 1'b0);
        eb = mag(i, 1'b1);
        cyc(6);
        chk(phase_a_level, ea);
        chk(phase_b_level, eb);
        chk({6'h00, home_flag_out_i}, {6'h00, i != HOME_INDEX});
        if (ea != 7'h00) chk({6'h00, phase_a_reverse}, {6'h00, i[5] ^ i[4]});
        if (eb != 7'h00) chk({6'h00, phase_b_reverse}, {6'h00, i[5]});
    endtask

    // Holds reset low while the selects change, then releases it
    task automatic rehome(input logic [1:0] code);
        motion_reset_n = 1'b0;
        {resolution_select_b, resolution_select_a} = code;
        cyc(6);
        motion_reset_n = 1'b1;
        cyc(4);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        motion_reset_n = 1'b0;
        drive_enable = 1'b1;
        sleep_input_n = 1'b1;
        {resolution_select_b, resolution_select_a} = 2'h0;
        torque_select = 1'b1;
        cyc(16);
        sys_rst = 1'b0;
        check_pos(HOME_INDEX);
        torque_select = 1'b0;
        cyc(6);
        chk(phase_a_level, 7'h19);
        torque_select = 1'b1;
        cyc(1200);
        seek_gates(GATES_CHARGE);
        seek_gates(GATES_SLOW);
        seek_gates(GATES_FAST);
        for (int m = 0; m < 4; m++) begin
            rehome(2'(m));
            host.pulse(1'b0, 1);
            check_pos(INCS[m]);
        end
        resolution_select_a = 1'b0;
        check_pos(HOME_INDEX);
        host.pulse(1'b0, 1);
        check_pos(6'h04);
        drive_enable = 1'b0;
        cyc(6);
        chk({6'h00, |gates}, 7'h00);
        chk({6'h00, drive_active}, 7'h00);
        host.pulse(1'b0, 2);
        drive_enable = 1'b1;
        check_pos(6'h0C);
        sleep_input_n = 1'b0;
        motion_reset_n = 1'b0;
        cyc(6);
        chk({6'h00, |gates}, 7'h00);
        check_pos(6'h0C);
        sleep_input_n = 1'b1;
        check_pos(HOME_INDEX);
        host.hold(1'b1);
        cyc(4);
        motion_reset_n = 1'b1;
        check_pos(6'h04);
        host.hold(1'b0);
        check_pos(6'h04);
        torque_select = 1'b0;
        cyc(6);
        chk(phase_a_level, mag(6'h04, 1'b0) >> 2);
        torque_select = 1'b1;
        rehome(MODE_SIXTEENTH);
        host.pulse(1'b1, 1);
        check_pos(6'h3F);
        host.pulse(1'b0, 2);
        check_pos(6'h01);
        rehome(MODE_HALF);
        for (int k = 1; k < 8; k++) begin
            host.pulse(1'b0, 1);
            check_pos(6'(8 * k));
        end
        tally_and_finish();
    end
endmodule

// *** verification/step_host_model.sv ***
`timescale 1ns/1ps
module step_host_model (
    input  wire logic ref_clk,
    output logic      step_clock,
    output logic      rotation_direction,
    output logic      chop_oscillator,
    output logic      sense_phase_a,
    output logic      sense_phase_b
);
    logic [8:0] osc_count;

    initial begin
        osc_count = 9'h000;
        step_clock = 1'b0;
        rotation_direction = 1'b0;
    end

    // Slow oscillator so every bridge state outlasts the dead time
    always @(negedge ref_clk) begin
        osc_count <= osc_count + 9'h001;
    end
    assign chop_oscillator = osc_count[5];
    // Comparators trip part way through a chopping period
    assign sense_phase_a = (osc_count[8:6] == 3'h2);
    assign sense_phase_b = (osc_count[8:6] == 3'h5);

    task automatic pulse(input logic dir, input int n);
        rotation_direction = dir;
        repeat (n) begin
            @(negedge ref_clk);
            step_clock = 1'b1;
            repeat (3) @(negedge ref_clk);
            step_clock = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    endtask

    task automatic hold(input logic level);
        step_clock = level;
    endtask
endmodule
